// *** logic/rai_top.sv ***
// interrupt flags, gating, pin steering and watchdog reset of the rtc
`timescale 1ns/1ps
`default_nettype none
module rai_top #(
  parameter int RESET_CYCLES = rai_pkg::WD_RESET_CYC
) (
  input  wire logic              I_CLK,
  input  wire logic              I_RST,
  input  wire rai_pkg::rai_req_t I_REQ,
  output var  logic [7:0]        O_RDATA,
  input  wire logic [6:0]        I_FIELD_EQ,
  input  wire logic              I_COUNTDOWN_ZERO,
  input  wire logic              I_WATCHDOG_EXPIRE,
  input  wire logic              I_OSC_FAIL,
  input  wire logic              I_AUTOCAL_FAIL,
  input  wire logic              I_BATTERY_ABOVE,
  input  wire logic              I_EXTERNAL_INPUT_ONE,
  input  wire logic              I_EXTERNAL_INPUT_TWO,
  output var  logic              O_MULTIPURPOSE_OUT_ONE_N,
  output var  logic              O_MULTIPURPOSE_OUT_TWO_N,
  output var  logic              O_TIMER_REQUEST_PIN_N,
  output var  logic              O_CLOCK_OUT_N,
  output var  logic              O_SYSTEM_RESET_OUT_N,
  output var  logic [7:0]        O_COUNTDOWN_CTRL,
  output var  logic [4:0]        O_WATCHDOG_TIMEOUT_COUNT,
  output var  logic [3:0]        O_BATTERY_THRESHOLD_SEL
);
  localparam int RW = $clog2(RESET_CYCLES + 1);
  localparam int PW = rai_pkg::PULSE_W;
  localparam int NF = rai_pkg::NFLAG;

  if (RESET_CYCLES < 1) begin : g_chk
    $error("rai_top: RESET_CYCLES must be at least 1");
  end

  typedef enum logic {RAI_WR_IDLE, RAI_WR_HOLD} rai_wr_state_t;

  function automatic logic [PW-1:0] pulse_len(input logic [1:0] idx);
    case (idx)
      2'h0: pulse_len = rai_pkg::PULSE0_CYC;
      2'h1: pulse_len = rai_pkg::PULSE1_CYC;
      2'h2: pulse_len = rai_pkg::PULSE2_CYC;
      default: pulse_len = rai_pkg::PULSE3_CYC;
    endcase
  endfunction

  function automatic logic hit(input rai_pkg::rai_req_t r, input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction

  // control registers
  logic [NF-1:0] flags_reg;
  logic [NF-1:0] flags_next;
  logic [7:0]    mask_reg;
  logic [7:0]    ctrl2_reg;
  logic [7:0]    sqw_reg;
  logic [7:0]    cdt_reg;
  logic [7:0]    wdt_reg;
  logic [7:0]    oscc_reg;
  logic [7:0]    oscs_reg;
  logic [7:0]    oscs_next;
  logic [7:0]    battery_threshold_sel_reg;
  logic [7:0]    batio_reg;
  logic [7:0]    xram_reg;
  logic [7:0]    rdata_reg;
  logic [7:0]    rd_mux;

  // pin synchronisers {battery, ext two, ext one}
  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic [2:0] s3_reg;
  logic [2:0] stable_reg;
  logic [2:0] stable_next;
  logic [2:0] trig_lvl;
  logic [2:0] trig_prev_reg;
  logic [2:0] pol_vec;
  logic [2:0] pin_ev;

  logic          match_reg;
  logic          alm_match;
  logic [6:0]    alm_need;
  logic [2:0]    alm_rpt;
  logic [NF-1:0] ev;
  logic [NF-1:0] keep;
  logic [1:0]    osc_ev;
  logic [1:0]    pulse_trig;
  logic [PW-1:0] pulse_len_v [2];
  logic [1:0]    pulse_act;
  logic [1:0]    alm_shape;
  logic          wd_armed;
  logic          wd_steer;
  logic          auto_clear;
  logic          st_read;
  logic [7:0]    req_vec;
  logic          irq;
  logic          out1_reg;
  logic          out2_reg;
  logic          tpin_reg;
  logic          clko_reg;
  logic [RW-1:0] hold_reg;
  logic [RW-1:0] hold_next;
  rai_wr_state_t wr_state_reg;
  rai_wr_state_t wr_state_next;

  assign stable_next = (s2_reg & s3_reg) | (stable_reg & (s2_reg ^ s3_reg));
  assign pol_vec = {battery_threshold_sel_reg[rai_pkg::BR_BATTERY_EDGE_POLARITY], battery_threshold_sel_reg[rai_pkg::BR_X2P],
                    battery_threshold_sel_reg[rai_pkg::BR_X1P]};
  // polarity 1 arms rising, 0 falling; a polarity change can fire at once
  assign trig_lvl = ~(stable_reg ^ pol_vec);
  assign pin_ev   = trig_lvl & ~trig_prev_reg;

  // alarm: repeat value r compares fields 0..7-r, zero disables
  assign alm_rpt   = xram_reg[rai_pkg::XR_RPT_LSB +: 3];
  assign alm_need  = (alm_rpt == 3'h0) ? 7'h00 : (rai_pkg::ALM_ALL >> (alm_rpt - 3'h1));
  assign alm_match = (alm_rpt != 3'h0) && (&(I_FIELD_EQ | ~alm_need));

  assign wd_steer = wdt_reg[rai_pkg::WD_STEER];
  assign wd_armed = (wdt_reg[rai_pkg::WD_CNT_LSB +: 5] != 5'h00);

  assign ev[rai_pkg::F_EXT1] = pin_ev[0];
  assign ev[rai_pkg::F_EXT2] = pin_ev[1];
  assign ev[rai_pkg::F_BL]   = pin_ev[2];
  assign ev[rai_pkg::F_ALM]  = alm_match & ~match_reg;
  assign ev[rai_pkg::F_TIM]  = I_COUNTDOWN_ZERO & cdt_reg[rai_pkg::CD_RUN];
  assign ev[rai_pkg::F_WDT]  = I_WATCHDOG_EXPIRE & wd_armed;
  assign osc_ev = {I_OSC_FAIL, I_AUTOCAL_FAIL};

  // status write keeps bits written 1; auto-clear read keeps none
  assign auto_clear = mask_reg[rai_pkg::M_AUTO_CLEAR_ON_READ];
  assign st_read = I_REQ.rd && (I_REQ.addr == rai_pkg::ADDR_STATUS);
  assign keep = hit(I_REQ, rai_pkg::ADDR_STATUS) ? I_REQ.wdata[NF-1:0]
              : (st_read && auto_clear) ? '0 : '1;
  assign flags_next = (flags_reg & keep) | ev;
  assign oscs_next = hit(I_REQ, rai_pkg::ADDR_OSC_STAT)
                   ? ((oscs_reg & I_REQ.wdata) | {6'h00, osc_ev})
                   : (oscs_reg | {6'h00, osc_ev});

  // pulse shapers: 0 alarm, 1 countdown
  assign alm_shape = mask_reg[rai_pkg::M_SHAPE_LSB +: 2];
  assign pulse_trig = {ev[rai_pkg::F_TIM], ev[rai_pkg::F_ALM]};
  assign pulse_len_v[0] = pulse_len(alm_shape);
  assign pulse_len_v[1] = pulse_len(cdt_reg[rai_pkg::CD_FREQ_LSB +: 2]);

  for (genvar g = 0; g < 2; g++) begin : g_pulse
    rai_pulse #(.W(PW)) u_pulse (
      .i_clk    (I_CLK),
      .i_rst    (I_RST),
      .i_trig   (pulse_trig[g]),
      .i_len    (pulse_len_v[g]),
      .o_active (pulse_act[g])
    );
  end

  // per-source requests, each gated by its enable; watchdog by steer 0 and nonzero count
  assign req_vec[0] = mask_reg[rai_pkg::F_ALM] & ((alm_shape == 2'h0) ?
                      flags_reg[rai_pkg::F_ALM] : pulse_act[0]);
  assign req_vec[1] = mask_reg[rai_pkg::F_TIM] & (cdt_reg[rai_pkg::CD_SHAPE] ?
                      pulse_act[1] : flags_reg[rai_pkg::F_TIM]);
  assign req_vec[2] = ~wd_steer & wd_armed & flags_reg[rai_pkg::F_WDT];
  assign req_vec[3] = mask_reg[rai_pkg::F_BL] & flags_reg[rai_pkg::F_BL];
  assign req_vec[4] = mask_reg[rai_pkg::F_EXT1] & flags_reg[rai_pkg::F_EXT1];
  assign req_vec[5] = mask_reg[rai_pkg::F_EXT2] & flags_reg[rai_pkg::F_EXT2];
  assign req_vec[6] = oscc_reg[rai_pkg::OC_OSC_FAIL_ENABLE] & oscs_reg[rai_pkg::OS_OF];
  assign req_vec[7] = oscc_reg[rai_pkg::OC_AUTOCAL_FAIL_ENABLE] & oscs_reg[rai_pkg::OS_ACF];
  assign irq = |req_vec;

  // read selection
  assign rd_mux =
      (I_REQ.addr == rai_pkg::ADDR_STATUS)   ? {2'h0, flags_reg} :
      (I_REQ.addr == rai_pkg::ADDR_CTRL2)    ? ctrl2_reg :
      (I_REQ.addr == rai_pkg::ADDR_MASK)     ? mask_reg :
      (I_REQ.addr == rai_pkg::ADDR_SQW)      ? sqw_reg :
      (I_REQ.addr == rai_pkg::ADDR_CDT)      ? cdt_reg :
      (I_REQ.addr == rai_pkg::ADDR_WDT)      ? wdt_reg :
      (I_REQ.addr == rai_pkg::ADDR_OSC_CTRL) ? oscc_reg :
      (I_REQ.addr == rai_pkg::ADDR_OSC_STAT) ? oscs_reg :
      (I_REQ.addr == rai_pkg::ADDR_BATTERY_THRESHOLD_SEL)     ? battery_threshold_sel_reg :
      (I_REQ.addr == rai_pkg::ADDR_BATIO)    ? batio_reg :
      (I_REQ.addr == rai_pkg::ADDR_XRAM)     ? ((xram_reg & rai_pkg::XR_RW_MASK) |
        (8'(stable_reg[0]) << rai_pkg::XR_EXT_ONE_PIN_LEVEL) |
        (8'(stable_reg[1]) << rai_pkg::XR_EXT_TWO_PIN_LEVEL)) :
      rai_pkg::BYTE_ZERO;

  // watchdog reset hold
  always_comb begin
    wr_state_next = wr_state_reg;
    hold_next = hold_reg;
    unique case (wr_state_reg)
      RAI_WR_IDLE: begin
        if (ev[rai_pkg::F_WDT] && wd_steer) begin
          wr_state_next = RAI_WR_HOLD;
          hold_next = RW'(RESET_CYCLES);
        end
      end
      RAI_WR_HOLD: begin
        hold_next = hold_reg - RW'(1);
        if (hold_reg == RW'(1)) begin
          wr_state_next = RAI_WR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      s1_reg        <= 3'h0;
      s2_reg        <= 3'h0;
      s3_reg        <= 3'h0;
      stable_reg    <= 3'h0;
      trig_prev_reg <= 3'h7;
      match_reg     <= 1'b0;
    end else begin
      s1_reg        <= {I_BATTERY_ABOVE, I_EXTERNAL_INPUT_TWO, I_EXTERNAL_INPUT_ONE};
      s2_reg        <= s1_reg;
      s3_reg        <= s2_reg;
      stable_reg    <= stable_next;
      trig_prev_reg <= trig_lvl;
      match_reg     <= alm_match;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      flags_reg <= '0;
      oscs_reg  <= rai_pkg::OSC_STAT_RST;
      rdata_reg <= rai_pkg::BYTE_ZERO;
    end else begin
      flags_reg <= flags_next;
      oscs_reg  <= oscs_next;
      rdata_reg <= I_REQ.rd ? rd_mux : rdata_reg;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      mask_reg  <= rai_pkg::BYTE_ZERO;
      ctrl2_reg <= rai_pkg::BYTE_ZERO;
      sqw_reg   <= rai_pkg::BYTE_ZERO;
      cdt_reg   <= rai_pkg::BYTE_ZERO;
      wdt_reg   <= rai_pkg::BYTE_ZERO;
      oscc_reg  <= rai_pkg::BYTE_ZERO;
      battery_threshold_sel_reg  <= rai_pkg::BYTE_ZERO;
      batio_reg <= rai_pkg::BYTE_ZERO;
      xram_reg  <= rai_pkg::BYTE_ZERO;
    end else begin
      mask_reg  <= hit(I_REQ, rai_pkg::ADDR_MASK) ? I_REQ.wdata : mask_reg;
      ctrl2_reg <= hit(I_REQ, rai_pkg::ADDR_CTRL2) ? I_REQ.wdata : ctrl2_reg;
      sqw_reg   <= hit(I_REQ, rai_pkg::ADDR_SQW) ? I_REQ.wdata : sqw_reg;
      cdt_reg   <= hit(I_REQ, rai_pkg::ADDR_CDT) ? I_REQ.wdata : cdt_reg;
      wdt_reg   <= hit(I_REQ, rai_pkg::ADDR_WDT) ? I_REQ.wdata : wdt_reg;
      oscc_reg  <= hit(I_REQ, rai_pkg::ADDR_OSC_CTRL) ? I_REQ.wdata : oscc_reg;
      battery_threshold_sel_reg  <= hit(I_REQ, rai_pkg::ADDR_BATTERY_THRESHOLD_SEL) ? I_REQ.wdata : battery_threshold_sel_reg;
      batio_reg <= hit(I_REQ, rai_pkg::ADDR_BATIO) ? I_REQ.wdata : batio_reg;
      xram_reg  <= hit(I_REQ, rai_pkg::ADDR_XRAM) ? I_REQ.wdata : xram_reg;
    end
  end

  // registered pins, inverted request
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      out1_reg     <= 1'b1;
      out2_reg     <= 1'b1;
      tpin_reg     <= 1'b1;
      clko_reg     <= 1'b1;
      wr_state_reg <= RAI_WR_IDLE;
      hold_reg     <= '0;
    end else begin
      out1_reg <= ~(irq && ctrl2_reg[rai_pkg::C2_OUT1_LSB +: 3] == rai_pkg::OUT1_SEL_IRQ);
      out2_reg <= ~(irq && ctrl2_reg[rai_pkg::C2_OUT2_LSB +: 3] == rai_pkg::OUT2_SEL_IRQ);
      tpin_reg <= ~req_vec[1];
      clko_reg <= ~(req_vec[1] && sqw_reg[4:0] == rai_pkg::SQW_SEL_TIMER);
      wr_state_reg <= wr_state_next;
      hold_reg     <= hold_next;
    end
  end

  assign O_RDATA                  = rdata_reg;
  assign O_MULTIPURPOSE_OUT_ONE_N = out1_reg;
  assign O_MULTIPURPOSE_OUT_TWO_N = out2_reg;
  assign O_TIMER_REQUEST_PIN_N    = tpin_reg;
  assign O_CLOCK_OUT_N            = clko_reg;
  assign O_SYSTEM_RESET_OUT_N     = (wr_state_reg != RAI_WR_HOLD);
  assign O_COUNTDOWN_CTRL         = cdt_reg;
  assign O_WATCHDOG_TIMEOUT_COUNT = wdt_reg[rai_pkg::WD_CNT_LSB +: 5];
  assign O_BATTERY_THRESHOLD_SEL  = battery_threshold_sel_reg[rai_pkg::BR_SEL_LSB +: 4];

  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  AST_PIN_ONE: assert property (
    (irq && ctrl2_reg[rai_pkg::C2_OUT1_LSB +: 3] == rai_pkg::OUT1_SEL_IRQ)
      |=> !O_MULTIPURPOSE_OUT_ONE_N)
    else $error("pin one not low for request");
  AST_PIN_TWO_IDLE: assert property (
    !irq |=> O_MULTIPURPOSE_OUT_TWO_N && O_MULTIPURPOSE_OUT_ONE_N)
    else $error("request pin low without request");
  AST_WD_STEER: assert property (
    (flags_reg[rai_pkg::F_WDT] && wd_armed && !wd_steer &&
     ctrl2_reg[rai_pkg::C2_OUT2_LSB +: 3] == rai_pkg::OUT2_SEL_IRQ)
      |=> !O_MULTIPURPOSE_OUT_TWO_N)
    else $error("watchdog flag without interrupt");
  AST_WD_ZERO: assert property (
    (!wd_armed && !flags_reg[rai_pkg::F_WDT] && !(hit(I_REQ, rai_pkg::ADDR_WDT)))
      |=> !flags_reg[rai_pkg::F_WDT] && O_SYSTEM_RESET_OUT_N)
    else $error("watchdog acted with zero count");
  AST_LEVEL_HOLD: assert property (
    (flags_reg[rai_pkg::F_BL] && keep[rai_pkg::F_BL]) |=> flags_reg[rai_pkg::F_BL])
    else $error("battery flag dropped without clear");
  AST_MASKED: assert property (
    (req_vec == 8'h00) |-> !irq ##1 O_MULTIPURPOSE_OUT_ONE_N)
    else $error("masked flag reached pin");
  AST_WRITE_ZERO: assert property (
    hit(I_REQ, rai_pkg::ADDR_STATUS) |=>
      flags_reg == (($past(flags_reg) & $past(I_REQ.wdata[5:0])) | $past(ev)))
    else $error("status write result wrong");
  AST_AUTO_CLEAR: assert property (
    (st_read && auto_clear) |=> (O_RDATA[5:0] == $past(flags_reg)) && (flags_reg == $past(ev)))
    else $error("auto-clear read wrong");
  AST_OSC_KEEP: assert property (
    (st_read && oscs_reg[rai_pkg::OS_OF] && !hit(I_REQ, rai_pkg::ADDR_OSC_STAT))
      |=> oscs_reg[rai_pkg::OS_OF])
    else $error("oscillator flag cleared by read");
  AST_WD_RESET: assert property (
    (ev[rai_pkg::F_WDT] && wd_steer && wr_state_reg == RAI_WR_IDLE) |=> !O_SYSTEM_RESET_OUT_N [*8])
    else $error("watchdog reset too short");

  COV_ALARM: cover property (ev[rai_pkg::F_ALM] ##[1:20] !O_MULTIPURPOSE_OUT_ONE_N);
  COV_AUTO_CLEAR_ON_READ: cover property (st_read && auto_clear && flags_reg != '0);
  COV_WD_RESET: cover property (!O_SYSTEM_RESET_OUT_N);
endmodule
`default_nettype wire

// *** logic/rai_pkg.sv ***
// constants and carrier types for the rtc interrupt aggregator
// How it works
// - enabled set flags are ORed into one combined request
// - output-select fields steer the request onto pin one or pin two
// - request pins show the request inverted, active low
// - watchdog flag raises interrupt when steer is 0, reset when 1
// - watchdog does nothing while its timeout count is zero
// - level-only sources hold the request until software clears the flag
// - a flag reaches a pin only when its enable is set; watchdog needs steer 0 and a nonzero count
// - alarm flag sets when the repeat-selected time fields all match
// - alarm output shape picks level or pulse and pulse length
// - countdown zero sets its flag while run is set; shape fields time it
// - timer request always drives timer pin; square-wave select may add clock pin
// - watchdog flag sets when the watchdog reaches timeout
// - battery flag sets on comparator crossing; polarity picks falling or rising
// - external flags set on input edges; per-input polarity picks the edge
// - live levels of both external inputs are readable
// - oscillator and autocal failures set flags that request when enabled
// - writing zero clears a flag; a status write updates all flags at once
// - with auto-clear set, a status read returns flags then clears them
// - an event coinciding with an auto-clear read is never lost
// - oscillator and autocal flags ignore auto-clear reads; direct write clears
// - watchdog with steer set asserts system reset for about 60 ms
package rai_pkg;
  localparam logic [7:0] ADDR_STATUS   = 8'h0F;
  localparam logic [7:0] ADDR_CTRL2    = 8'h11;
  localparam logic [7:0] ADDR_MASK     = 8'h12;
  localparam logic [7:0] ADDR_SQW      = 8'h13;
  localparam logic [7:0] ADDR_CDT      = 8'h18;
  localparam logic [7:0] ADDR_WDT      = 8'h1B;
  localparam logic [7:0] ADDR_OSC_CTRL = 8'h1C;
  localparam logic [7:0] ADDR_OSC_STAT = 8'h1D;
  localparam logic [7:0] ADDR_BATTERY_THRESHOLD_SEL     = 8'h21;
  localparam logic [7:0] ADDR_BATIO    = 8'h27;
  localparam logic [7:0] ADDR_XRAM     = 8'h3F;
  // status flag and enable positions
  localparam int NFLAG = 6;
  localparam int F_EXT1 = 0;
  localparam int F_EXT2 = 1;
  localparam int F_ALM  = 2;
  localparam int F_TIM  = 3;
  localparam int F_BL   = 4;
  localparam int F_WDT  = 5;
  localparam int M_SHAPE_LSB = 5;
  localparam int M_AUTO_CLEAR_ON_READ      = 7;
  localparam int C2_OUT1_LSB = 0;
  localparam int C2_OUT2_LSB = 3;
  localparam logic [2:0] OUT1_SEL_IRQ = 3'h0;
  localparam logic [2:0] OUT2_SEL_IRQ = 3'h3;
  localparam logic [4:0] SQW_SEL_TIMER = 5'h1B;
  localparam int CD_RUN   = 7;
  localparam int CD_SHAPE = 6;
  localparam int CD_FREQ_LSB = 0;
  localparam int WD_STEER   = 7;
  localparam int WD_CNT_LSB = 2;
  localparam int OC_OSC_FAIL_ENABLE = 1;
  localparam int OC_AUTOCAL_FAIL_ENABLE = 0;
  localparam int OS_OF  = 1;
  localparam int OS_ACF = 0;
  localparam int BR_BATTERY_EDGE_POLARITY = 0;
  localparam int BR_X1P  = 1;
  localparam int BR_X2P  = 2;
  localparam int BR_SEL_LSB = 4;
  localparam int XR_EXT_ONE_PIN_LEVEL = 5;
  localparam int XR_EXT_TWO_PIN_LEVEL = 4;
  localparam int XR_RPT_LSB = 5;
  localparam logic [7:0] XR_RW_MASK   = 8'hCF;
  localparam logic [7:0] OSC_STAT_RST = 8'h02;
  localparam logic [7:0] BYTE_ZERO    = 8'h00;
  localparam logic [6:0] ALM_ALL      = 7'h7F;
  // timing at a 50 MHz clock
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_NS = 20;
  localparam int WD_RESET_MS  = 60;
  localparam int WD_RESET_CYC = WD_RESET_MS * (CLK_HZ / 1000);
  localparam int PULSE_W = 12;
  localparam int PULSE0_NS = 200;
  localparam int PULSE1_NS = 2000;
  localparam int PULSE2_NS = 20000;
  localparam int PULSE3_NS = 60000;
  localparam logic [PULSE_W-1:0] PULSE0_CYC = PULSE_W'(PULSE0_NS / CLK_NS);
  localparam logic [PULSE_W-1:0] PULSE1_CYC = PULSE_W'(PULSE1_NS / CLK_NS);
  localparam logic [PULSE_W-1:0] PULSE2_CYC = PULSE_W'(PULSE2_NS / CLK_NS);
  localparam logic [PULSE_W-1:0] PULSE3_CYC = PULSE_W'(PULSE3_NS / CLK_NS);

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rai_req_t;
endpackage

// *** logic/rai_pulse.sv ***
// one-shot stretcher for pulse-shaped requests
`timescale 1ns/1ps
`default_nettype none
module rai_pulse #(
  parameter int W = 12
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_trig,
  input  wire logic [W-1:0] i_len,
  output var  logic         o_active
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  if (W < 2) begin : g_chk
    $error("rai_pulse: W too small");
  end

  // retrigger reloads the length
  assign cnt_next = i_trig ? i_len : ((cnt_reg != '0) ? cnt_reg - W'(1) : cnt_reg);
  assign o_active = (cnt_reg != '0);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

// *** testbench/rai_host.sv ***
// host model that reaches the registers and services requests
`timescale 1ns/1ps
`default_nettype none
module rai_host (
  input  wire logic              i_clk,
  input  wire logic [7:0]        i_rdata,
  output var  rai_pkg::rai_req_t o_req
);
  initial o_req = '{1'b0, 1'b0, 8'hA5, 8'h5A};

  // idle cycles show inverted address and data, never the old values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk) #1;
    o_req = '{1'b1, 1'b0, a, d};
    @(posedge i_clk) #1;
    o_req = '{1'b0, 1'b0, ~a, ~d};
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk) #1;
    o_req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge i_clk) #1;
    o_req = '{1'b0, 1'b0, ~a, 8'hFF};
    d = i_rdata;
  endtask

  // reread status until no flag is left, at most 8 reads, returning all flags seen
  task automatic service(output logic [7:0] seen);
    logic [7:0] v;
    seen = 8'h00;
    for (int i = 0; i < 8; i++) begin
      rd(rai_pkg::ADDR_STATUS, v);
      seen = seen | v;
      if (v === 8'h00) break;
    end
  endtask
endmodule
`default_nettype wire

// *** testbench/test_rai_top.sv ***
// self-checking bench for the rtc interrupt aggregator
`timescale 1ns/1ps
`default_nettype none
module test_rai_top;
  localparam int RC = 20;
  localparam logic [7:0] ST = rai_pkg::ADDR_STATUS;
  localparam logic [7:0] C2 = rai_pkg::ADDR_CTRL2;
  localparam logic [7:0] MK = rai_pkg::ADDR_MASK;
  localparam logic [7:0] SQ = rai_pkg::ADDR_SQW;
  localparam logic [7:0] CD = rai_pkg::ADDR_CDT;
  localparam logic [7:0] WD = rai_pkg::ADDR_WDT;
  localparam logic [7:0] OC = rai_pkg::ADDR_OSC_CTRL;
  localparam logic [7:0] OS = rai_pkg::ADDR_OSC_STAT;
  localparam logic [7:0] BR = rai_pkg::ADDR_BATTERY_THRESHOLD_SEL;
  localparam logic [7:0] XR = rai_pkg::ADDR_XRAM;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [6:0]        feq = 7'h00;
  logic [3:0]        ev  = 4'h0;
  logic              bat = 1'b1;
  logic              x1  = 1'b1;
  logic              x2  = 1'b0;
  logic [7:0]        v;
  logic [7:0]        w;
  logic [7:0]        rdata;
  logic [4:0]        wcnt;
  logic [7:0]        cdc;
  logic [3:0]        bsel;
  rai_pkg::rai_req_t req;
  logic              p1_n, p2_n, tp_n, ck_n, rs_n;
  wire logic [4:0]   pins = {rs_n, ck_n, tp_n, p2_n, p1_n};
  int                errors = 0;
  int                n_compared = 0;
  int                cyc = 0;
  int                n;

  always #10 clk = ~clk;

  rai_host host (.i_clk(clk), .i_rdata(rdata), .o_req(req));

  rai_top #(.RESET_CYCLES(RC)) uut (
    .I_CLK(clk), .I_RST(rst), .I_REQ(req), .O_RDATA(rdata), .I_FIELD_EQ(feq),
    .I_COUNTDOWN_ZERO(ev[0]), .I_WATCHDOG_EXPIRE(ev[1]), .I_OSC_FAIL(ev[2]),
    .I_AUTOCAL_FAIL(ev[3]), .I_BATTERY_ABOVE(bat), .I_EXTERNAL_INPUT_ONE(x1),
    .I_EXTERNAL_INPUT_TWO(x2), .O_MULTIPURPOSE_OUT_ONE_N(p1_n),
    .O_MULTIPURPOSE_OUT_TWO_N(p2_n), .O_TIMER_REQUEST_PIN_N(tp_n),
    .O_CLOCK_OUT_N(ck_n), .O_SYSTEM_RESET_OUT_N(rs_n), .O_COUNTDOWN_CTRL(cdc),
    .O_WATCHDOG_TIMEOUT_COUNT(wcnt), .O_BATTERY_THRESHOLD_SEL(bsel)
  );

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask

  task automatic pulse(input int b);
    @(posedge clk) #1 ev[b] = 1'b1;
    @(posedge clk) #1 ev[b] = 1'b0;
  endtask

  task automatic cw(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // length of the next low period on one pin
  task automatic lowlen(input int b, output int m);
    m = 0;
    for (int i = 0; i < 4000; i++) begin
      if (pins[b] === 1'b0) m++;
      else if (m > 0) break;
      @(posedge clk) #1;
    end
  endtask

  task automatic end_sim;
    if (errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    cw(4);
    chk1(p1_n, 1'b1);
    chk1(rs_n, 1'b1);
    host.rd(OS, v);
    chk8(v, 8'h02);
    host.wr(OS, 8'h00);
    host.wr(C2, 8'h18);
    x1 = 1'b0;
    cw(10);
    chk1(p1_n, 1'b1);
    host.rd(ST, v);
    chk8(v, 8'h01);
    host.rd(XR, v);
    chk8(v & 8'h30, 8'h00);
    host.wr(MK, 8'h01);
    cw(2);
    chk1(p1_n, 1'b0);
    chk1(p2_n, 1'b0);
    host.wr(C2, 8'h19);
    cw(2);
    chk1(p1_n, 1'b1);
    host.wr(ST, 8'hFF);
    cw(20);
    chk1(p2_n, 1'b0);
    host.wr(ST, 8'hFE);
    cw(2);
    chk1(p2_n, 1'b1);
    host.wr(BR, 8'h54);
    chk8({4'h0, bsel}, 8'h05);
    host.wr(ST, 8'h00);
    x1 = 1'b1;
    x2 = 1'b1;
    bat = 1'b0;
    cw(10);
    host.rd(XR, v);
    chk8(v & 8'h30, 8'h30);
    host.rd(ST, v);
    chk8(v, 8'h12);
    host.wr(MK, 8'h10);
    cw(30);
    chk1(p2_n, 1'b0);
    host.wr(ST, 8'h00);
    host.wr(WD, 8'h00);
    pulse(1);
    cw(3);
    chk1(p2_n, 1'b1);
    chk1(rs_n, 1'b1);
    host.wr(WD, 8'h04);
    pulse(1);
    cw(3);
    chk1(p2_n, 1'b0);
    host.rd(ST, v);
    chk8(v, 8'h20);
    host.wr(ST, 8'h00);
    host.wr(WD, 8'h84);
    chk8({3'h0, wcnt}, 8'h01);
    pulse(1);
    lowlen(4, n);
    chk8(8'(n), 8'(RC));
    chk1(p2_n, 1'b1);
    host.wr(WD, 8'h00);
    host.wr(ST, 8'h00);
    host.wr(MK, 8'h24);
    host.wr(XR, 8'h20);
    feq = 7'h3F;
    cw(2);
    feq = 7'h00;
    host.rd(ST, v);
    chk8(v, 8'h00);
    host.wr(XR, 8'h40);
    feq = 7'h3F;
    @(posedge clk) #1 feq = 7'h00;
    lowlen(1, n);
    chk8(8'(n), 8'(rai_pkg::PULSE1_CYC));
    host.rd(ST, v);
    chk8(v, 8'h04);
    host.wr(XR, 8'h00);
    host.wr(ST, 8'h00);
    host.wr(MK, 8'h08);
    host.wr(CD, 8'h00);
    pulse(0);
    host.rd(ST, v);
    chk8(v, 8'h00);
    host.wr(CD, 8'h80);
    pulse(0);
    cw(3);
    chk1(tp_n, 1'b0);
    chk1(ck_n, 1'b1);
    host.wr(SQ, 8'h1B);
    cw(2);
    chk1(ck_n, 1'b0);
    host.wr(ST, 8'h00);
    host.wr(CD, 8'hC0);
    chk8(cdc, 8'hC0);
    pulse(0);
    lowlen(2, n);
    chk8(8'(n), 8'(rai_pkg::PULSE0_CYC));
    host.wr(MK, 8'h88);
    host.rd(ST, v);
    chk8(v, 8'h08);
    host.rd(ST, v);
    chk8(v, 8'h00);
    fork
      host.rd(ST, v);
      pulse(0);
    join
    host.rd(ST, w);
    chk8((v | w) & 8'h08, 8'h08);
    host.service(v);
    host.rd(ST, v);
    chk8(v, 8'h00);
    host.wr(OC, 8'h02);
    pulse(2);
    pulse(3);
    cw(2);
    chk1(p2_n, 1'b0);
    host.rd(ST, v);
    host.rd(OS, v);
    chk8(v, 8'h03);
    host.wr(OS, 8'h01);
    host.rd(OS, v);
    chk8(v, 8'h01);
    cw(2);
    chk1(p2_n, 1'b1);
    host.wr(OC, 8'h01);
    cw(2);
    chk1(p2_n, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
